// ===== serial_config_prom_output.sv
`timescale 1ns/1ps
module serial_config_prom_output
    import scfg_pkg::*;
#(
    parameter int WORD_W = WORD_W_DEF,
    parameter int MEM_WORDS = MEM_WORDS_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Synchronous reset
    input wire logic serial_shift_clock_i, // Shift clock pin level
    output logic serial_shift_clock_o, // Shift clock drive
    output logic serial_shift_clock_oe_o, // Shift clock enable
    output logic serial_data_o, // Serial data drive
    output logic serial_data_oe_o, // Serial data enable
    input wire logic enable_reset_i, // Enable/reset pin level
    output logic enable_reset_o, // Enable/reset drive level
    output logic enable_reset_oe_o, // Enable/reset pull low
    input wire logic select_in_n_i, // Chip select, low active
    output logic chain_next_select_n_o, // Cascade select, low active
    input wire logic prog_valid_i, // Store word request
    output logic prog_ready_o, // Store accepted
    input wire logic [$clog2(MEM_WORDS)-1:0] prog_addr_i, // Store word address
    input wire logic [WORD_W-1:0] prog_data_i // Store word data
);
    localparam int WADDR_W = $clog2(MEM_WORDS);
    localparam int BIDX_W = $clog2(WORD_W);
    localparam int TOTAL_BITS = MEM_WORDS * WORD_W;
    localparam int BADDR_W = $clog2(TOTAL_BITS);
    localparam logic [BADDR_W-1:0] LAST_BIT = BADDR_W'(TOTAL_BITS - 1);
    localparam logic [BIDX_W-1:0] LAST_IDX = BIDX_W'(WORD_W - 1);
    localparam logic [WADDR_W:0] WORD_COUNT = (WADDR_W+1)'(MEM_WORDS);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic oe_s1;
    logic oe_s2;
    logic cs_s1;
    logic cs_s2;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            oe_s1 <= 1'b0;
            oe_s2 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
        end else begin
            sclk_s1 <= serial_shift_clock_i;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            oe_s1 <= enable_reset_i;
            oe_s2 <= oe_s1;
            cs_s1 <= select_in_n_i;
            cs_s2 <= cs_s1;
        end
    end

    // Hold the shared enable/reset line low while in own reset
    assign enable_reset_o = 1'b0;
    assign enable_reset_oe_o = reset_i;

    // ----------------------------------------
    // Chain position strap
    // ----------------------------------------
    logic [1:0] strap_wait;
    logic first_member;

    wire strap_take = (strap_wait == 2'h1);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            strap_wait <= STRAP_WAIT;
            first_member <= 1'b0;
        end else begin
            if (strap_wait != 2'h0) begin
                strap_wait <= strap_wait - 2'h1;
            end
            if (strap_take) begin
                first_member <= ~cs_s2;
            end
        end
    end

    wire strap_ready = (strap_wait == 2'h0);

    // ----------------------------------------
    // Configuration store
    // ----------------------------------------
    logic [WORD_W-1:0] mem [MEM_WORDS];
    phase_t phase;

    assign prog_ready_o = (phase == PH_IDLE) & ~oe_s2;

    always_ff @(posedge clk_i) begin
        if (prog_valid_i && prog_ready_o) begin
            mem[prog_addr_i] <= prog_data_i;
        end
    end

    // ----------------------------------------
    // Prefetch into word buffer
    // ----------------------------------------
    logic [WADDR_W:0] fetch_cnt;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;

    wire fetch_valid = oe_s2 & (fetch_cnt != WORD_COUNT);
    wire [WADDR_W-1:0] fetch_addr = fetch_cnt[WADDR_W-1:0];
    wire fetch_push = fetch_valid & fifo_in_ready;

    always_ff @(posedge clk_i) begin
        if (reset_i || !oe_s2) begin
            fetch_cnt <= '0;
        end else if (fetch_push) begin
            fetch_cnt <= fetch_cnt + 1'b1;
        end
    end

    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .flush_i(~oe_s2),
        .in_valid_i(fetch_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem[fetch_addr]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ----------------------------------------
    // Enables and edge selection
    // ----------------------------------------
    logic [BADDR_W-1:0] bit_addr;
    logic [WORD_W-1:0] cur_word;
    logic word_valid;
    logic sclk_q;
    logic [DIV_W-1:0] div_cnt;

    wire done = (phase == PH_DONE);
    wire selected = ~cs_s2;
    wire count_en = oe_s2 & selected & ~done;
    wire run_clk = strap_ready & first_member & count_en & word_valid;
    wire div_zero = (div_cnt == '0);
    wire rise_int = div_zero & ~sclk_q & run_clk;
    wire rise_ext = sclk_s2 & ~sclk_d;
    wire rise = first_member ? rise_int : rise_ext;
    wire step = strap_ready & rise & count_en & word_valid;
    wire [BIDX_W-1:0] bit_idx = bit_addr[BIDX_W-1:0];
    wire word_end = step & (bit_idx == LAST_IDX);
    wire at_last = (bit_addr == LAST_BIT);

    assign fifo_out_ready = ~word_valid | word_end;

    // ----------------------------------------
    // Shift clock generator
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i || !oe_s2) begin
            sclk_q <= 1'b0;
            div_cnt <= DIV_LOAD;
        end else if (done) begin
            sclk_q <= 1'b0;
            div_cnt <= DIV_LOAD;
        end else if (!div_zero) begin
            div_cnt <= div_cnt - 1'b1;
        end else if (sclk_q || run_clk) begin
            sclk_q <= ~sclk_q;
            div_cnt <= DIV_LOAD;
        end
    end

    assign serial_shift_clock_o = sclk_q;
    assign serial_shift_clock_oe_o = strap_ready & first_member;

    // ----------------------------------------
    // Transfer phase and bit address
    // ----------------------------------------
    phase_t next_phase;

    always_comb begin
        next_phase = phase;
        case (phase)
            PH_IDLE: begin
                if (step) begin
                    next_phase = at_last ? PH_DONE : PH_SEND;
                end
            end
            PH_SEND: begin
                if (step && at_last) begin
                    next_phase = PH_DONE;
                end
            end
            PH_DONE: begin
                next_phase = PH_DONE;
            end
            default: begin
                next_phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || !oe_s2) begin
            phase <= PH_IDLE;
            bit_addr <= '0;
        end else begin
            phase <= next_phase;
            if (step && !at_last) begin
                bit_addr <= bit_addr + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Word register and data output
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i || !oe_s2) begin
            word_valid <= 1'b0;
            cur_word <= '0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            word_valid <= 1'b1;
            cur_word <= fifo_out_data;
        end else if (word_end) begin
            word_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            serial_data_o <= 1'b0;
        end else begin
            serial_data_o <= cur_word[bit_idx];
        end
    end

    // Last bit stays on the pin one cycle past the final rise
    logic done_q;

    always_ff @(posedge clk_i) begin
        if (reset_i || !oe_s2) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done;
        end
    end

    // Same float rule in every chain position
    assign serial_data_oe_o = oe_s2 & selected & ~done_q;
    assign chain_next_select_n_o = ~done;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_data_float_sel: assert property (
        cs_s2 |-> !serial_data_oe_o
    ) else $error("data drives with select high");

    a_data_float_done: assert property (
        (step && at_last) |=> ##1 !serial_data_oe_o && !chain_next_select_n_o
    ) else $error("data still drives after last bit");

    a_same_float_pos: assert property (
        (oe_s2 && selected && !done) |-> serial_data_oe_o
    ) else $error("data float depends on chain position");

    a_clk_drive_first: assert property (
        (strap_ready && first_member) |-> serial_shift_clock_oe_o
    ) else $error("first member not driving shift clock");

    a_clk_listen_later: assert property (
        !first_member |-> !serial_shift_clock_oe_o
    ) else $error("later member drives shift clock");

    a_addr_step: assert property (
        (step && !at_last) |=> bit_addr == $past(bit_addr) + 1'b1
    ) else $error("address did not step on rising edge");

    a_addr_hold: assert property (
        (oe_s2 && !count_en) [*2] |-> $stable(bit_addr)
    ) else $error("address moved while counting disabled");

    a_clk_low_idle: assert property (
        (first_member && (!oe_s2 || done)) |=> !serial_shift_clock_o
    ) else $error("shift clock not low when stopped");

    a_addr_clear: assert property (
        !oe_s2 |=> (bit_addr == '0) && chain_next_select_n_o
    ) else $error("address not cleared by enable low");

    a_strap_latch: assert property (
        strap_take |=> first_member == !$past(cs_s2)
    ) else $error("chain position strap mislatched");

    a_cascade_max: assert property (
        !chain_next_select_n_o |-> at_last
    ) else $error("cascade low before address maximum");

    a_cascade_hold: assert property (
        (done && oe_s2) |=> done && at_last
    ) else $error("cascade released while enabled");

    c_first_done: cover property (first_member && $rose(done));
    c_later_done: cover property (!first_member && $rose(done));
    c_abort_send: cover property ((phase == PH_SEND) ##1 !oe_s2);
    c_word_stall: cover property (oe_s2 && selected && !word_valid && !done);
endmodule

// ===== scfg_pkg.sv
// Summary of operation
// - Before sending starts, the data pin floats whenever the chip select is high.
// - After the last stored bit is sent, the data pin floats again.
// - The data pin floats the same way whether the memory is first or later in a chain.
// - Alone or first in a chain, the memory drives the shift clock itself.
// - As a later chain member, the memory only listens to the shift clock pin.
// - Each rising shift clock edge steps the bit address and shows the next bit.
// - The address steps only with enable high, select low and bits left; with enable high it otherwise holds.
// - A clock-driving memory holds the shift clock low when done or while enable is low.
// - A low enable/reset level returns the bit address to its start.
// - A high enable/reset level lets the data pin drive and the address count.
// - Enable/reset falling low mid-transfer stops the clock generator at once, clock low.
// - A low chip select lets clock edges step the address and lets the data pin drive.
// - Select low when reset releases makes the memory the first chain member.
// - Select high when reset releases makes the memory a later chain member.
// - The cascade output goes low once the bit at the maximum bit address has been stepped out.
package scfg_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int SCLK_HALF_NS = 50;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int DIV_W = $clog2(SCLK_HALF_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(SCLK_HALF_CYC - 1);
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ----------------------------------------
    // Storage defaults
    // ----------------------------------------
    localparam int WORD_W_DEF = 8;
    localparam int MEM_WORDS_DEF = 64;
    localparam int FIFO_DEPTH_DEF = 16;

    // ----------------------------------------
    // Transfer phases
    // ----------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_SEND = 3'b010,
        PH_DONE = 3'b100
    } phase_t;
endpackage

// ===== word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Synchronous reset
    input wire logic flush_i, // Drop all contents
    input wire logic in_valid_i, // Write request
    output logic in_ready_o, // Room for a word
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    output logic out_valid_o, // Word available
    input wire logic out_ready_i, // Read accept
    output logic [WIDTH-1:0] out_data_o // Oldest word
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] fill;

    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign in_ready_o = (fill != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (fill != '0);
    assign out_data_o = store[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule

// ===== cfg_target_model.sv
`timescale 1ns/1ps
module cfg_target_model (
    input wire logic sclk_i, // Shift clock wire
    input wire logic data_i, // Serial data wire
    input wire logic run_i, // Drive the shift clock
    input wire logic clear_i, // Restart capture
    output logic sclk_o, // Shift clock drive
    output logic [31:0] bits_o, // Captured stream
    output int count_o // Captured bit count
);
    initial begin
        sclk_o = 1'b0;
        bits_o = 32'h0;
        count_o = 0;
    end

    // Clock only within a frame, low between frames
    always begin
        wait (run_i);
        #32 sclk_o = 1'b1;
        #32 sclk_o = 1'b0;
    end

    always @(posedge clear_i) count_o = 0;

    // Take each bit at the rising shift clock
    always @(posedge sclk_i) begin
        #1;
        if (count_o < 32) bits_o[count_o] = data_i;
        count_o = count_o + 1;
    end
endmodule

// ===== serial_config_prom_output_test.sv
`timescale 1ns/1ps
module serial_config_prom_output_test;
    import scfg_pkg::*;
    localparam logic [31:0] STREAM = 32'hC10F3CA5;
    logic clk_i, reset_i, sel_n, en_low, prog_valid, run, clr, data_float;
    logic [1:0] prog_addr;
    logic [7:0] prog_data;
    logic sclk_o, sclk_oe, data_o, data_oe, en_o, en_oe, casc_n, prog_ready, model_sclk;
    logic [31:0] bits;
    wire sclk_wire, data_wire, en_wire;
    int count, bad_count, n_tests, cycles, k, n;

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    assign sclk_wire = sclk_oe ? sclk_o : model_sclk;
    assign data_wire = data_oe ? data_o : data_float;
    assign en_wire = !((en_oe && !en_o) || en_low);

    serial_config_prom_output #(.MEM_WORDS(4)) serial_config_prom_output_inst (
        .clk_i(clk_i), .reset_i(reset_i),
        .serial_shift_clock_i(sclk_wire), .serial_shift_clock_o(sclk_o),
        .serial_shift_clock_oe_o(sclk_oe), .serial_data_o(data_o),
        .serial_data_oe_o(data_oe), .enable_reset_i(en_wire), .enable_reset_o(en_o),
        .enable_reset_oe_o(en_oe), .select_in_n_i(sel_n), .chain_next_select_n_o(casc_n),
        .prog_valid_i(prog_valid), .prog_ready_o(prog_ready), .prog_addr_i(prog_addr),
        .prog_data_i(prog_data)
    );

    cfg_target_model cfg_target_model_inst (
        .sclk_i(sclk_wire), .data_i(data_wire), .run_i(run), .clear_i(clr),
        .sclk_o(model_sclk), .bits_o(bits), .count_o(count)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        data_float <= ~data_float;
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            bad_count++;
            stop_test;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task cyc(input int c);
        repeat (c) @(negedge clk_i);
    endtask

    task do_reset(input logic sel);
        reset_i = 1'b1;
        sel_n = sel;
        en_low = 1'b1;
        cyc(2);
        reset_i = 1'b0;
        cyc(8);
    endtask

    task load;
        for (int i = 0; i < 4; i++) begin
            prog_valid = 1'b1;
            prog_addr = 2'(i);
            prog_data = STREAM[8*i +: 8];
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (prog_ready !== 1'b1 && k < 50);
            @(negedge clk_i);
        end
        prog_valid = 1'b0;
    endtask

    task restart;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask

    task wait_bits(input int c);
        k = 0;
        while (count < c && k < 3000) begin
            @(negedge clk_i);
            k++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task test_master;
        do_reset(1'b0);
        chk(32'(sclk_oe), 32'h1, "clock drive");
        chk(32'(data_oe), 32'h0, "data idle");
        chk(32'(sclk_wire), 32'h0, "clock idle");
        load;
        restart;
        en_low = 1'b0;
        wait_bits(32);
        cyc(10);
        chk(bits, STREAM, "stream");
        chk(32'(data_oe), 32'h0, "data after done");
        chk(32'(casc_n), 32'h0, "cascade");
        chk(32'(sclk_wire), 32'h0, "clock after done");
        cyc(60);
        chk(count, 32'h20, "bit count");
        chk(32'(casc_n), 32'h0, "cascade held");
        $display("test_master finished");
    endtask

    task test_abort;
        en_low = 1'b1;
        cyc(4);
        chk(32'(casc_n), 32'h1, "cascade release");
        restart;
        en_low = 1'b0;
        wait_bits(10);
        en_low = 1'b1;
        cyc(4);
        chk(32'(sclk_wire), 32'h0, "clock stop");
        n = count;
        cyc(40);
        chk(count, n, "count frozen");
        chk(32'(data_oe), 32'h0, "data off");
        restart;
        en_low = 1'b0;
        wait_bits(32);
        cyc(10);
        chk(bits, STREAM, "restart stream");
        $display("test_abort finished");
    endtask

    task test_select;
        en_low = 1'b1;
        sel_n = 1'b1;
        cyc(4);
        restart;
        en_low = 1'b0;
        cyc(60);
        chk(32'(data_oe), 32'h0, "data unselected");
        chk(count, 32'h0, "no steps unselected");
        sel_n = 1'b0;
        wait_bits(32);
        cyc(10);
        chk(bits, STREAM, "selected stream");
        $display("test_select finished");
    endtask

    task test_later;
        do_reset(1'b1);
        chk(32'(sclk_oe), 32'h0, "clock listen");
        load;
        restart;
        en_low = 1'b0;
        cyc(20);
        chk(32'(data_oe), 32'h0, "data before select");
        sel_n = 1'b0; // Upstream cascade hands over
        cyc(10);
        run = 1'b1;
        wait_bits(32);
        run = 1'b0;
        cyc(12);
        chk(bits, STREAM, "later stream");
        chk(32'(data_oe), 32'h0, "later data done");
        chk(32'(casc_n), 32'h0, "later cascade");
        $display("test_later finished");
    endtask

    initial begin
        reset_i = 1'b1;
        sel_n = 1'b0;
        en_low = 1'b1;
        prog_valid = 1'b0;
        prog_addr = 2'h0;
        prog_data = 8'h00;
        run = 1'b0;
        clr = 1'b0;
        data_float = 1'b0;
        cycles = 0;
        bad_count = 0;
        n_tests = 0;
        @(negedge clk_i);
        test_master;
        test_abort;
        test_select;
        test_later;
        stop_test;
    end
endmodule
